// *** core/capture_compare_unit.sv ***
/*
 Sixteen-channel capture/compare unit with two reloadable time bases,
 an AHB-Lite register slave and one level interrupt.
 Assumes all inputs synchronous to hclk and a single-slave AHB-Lite bus.
*/
// What this block does
// - Sixteen independent capture/compare channels for timing sequences.
// - One-cycle resolution; staggered mode coarsens it to eight cycles.
// - Two 16-bit timers with reload registers serve as time bases.
// - Timer count clock selectable from prescaled system clock divisions.
// - Timers may advance on each neighbour timer overflow or underflow.
// - First time base can count an external input's rising edges.
// - Each of 16 registers picks a timer and compare use; only the twelve with a pin can capture.
// - Twelve channels own a pin: capture trigger or compare output.
// - Compare mode 0 only interrupts, repeatedly, pin untouched.
// - Compare mode 1 toggles the pin on every match.
// - Compare mode 2 interrupts at most once per timer period.
// - Mode 3 sets pin on match, clears it on timer overflow.
// - Double-register mode lets two registers toggle one shared pin.
// - Single-event option limits any compare mode to one event.
`timescale 1ns/1ps
`include "cc_map_map.svh"
module capture_compare_unit
    import cc_pkg::*;
#(
    parameter int NCH = 16,
    parameter int NPIN = 12,
    parameter int TW = 16
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Count sources
    input wire logic neighbour_evt,
    input wire logic ext_count_in,
    // Channel pins
    input wire logic [NPIN-1:0] cap_pin_in,
    output logic [NPIN-1:0] cmp_pin_out,
    output logic [NPIN-1:0] cmp_pin_oe,
    // Interrupt
    output logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    localparam int HALF = NCH / 2;
    localparam logic [TW-1:0] TMAX = '1;

    function automatic logic presc_hit(logic [7:0] c, logic [2:0] d);
        logic [7:0] m;
        m = ~(8'hff << d);
        return (c & m) == m;
    endfunction : presc_hit

    // Bus slave: zero wait states, writes land at the end of data phase
    logic bus_take;
    logic wr_q;
    logic [7:0] wa_q;
    logic [31:0] rd_d;
    logic [31:0] hrdata_q;
    assign bus_take = hsel && htrans[1] && hready;

    function automatic logic wr_at(logic w, logic [7:0] a, logic [7:0] r);
        return w && (a == r);
    endfunction : wr_at

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_q <= bus_take && hwrite;
            wa_q <= haddr[7:0];
        end
    end

    // Timers and count sources
    tmr_ctl_s tctl_q [2];
    logic [TW-1:0] cnt_q [2];
    logic [TW-1:0] rld_q [2];
    logic stagger_q;
    logic [7:0] presc_q;
    logic ext_prev_q;
    logic [1:0] tick;
    logic [1:0] tick_q;
    logic [1:0] ovf_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 8'h00;
            ext_prev_q <= 1'b0;
        end else begin
            presc_q <= presc_q + 8'h01;
            ext_prev_q <= ext_count_in;
        end
    end

    always_comb begin
        for (int t = 0; t < 2; t++) begin
            case (tctl_q[t].src)
                SRC_PRESCALE: tick[t] = presc_hit(presc_q, tctl_q[t].div)
                    && (!stagger_q
                        || presc_q[2:0] == `CC_STAGGER_PHASE);
                SRC_NEIGHBOUR: tick[t] = neighbour_evt;
                SRC_EXTERNAL: tick[t] = (t == 0)
                    && ext_count_in && !ext_prev_q;
                default: tick[t] = 1'b0;
            endcase
            tick[t] = tick[t] && tctl_q[t].run;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tctl_q[0] <= '0;
            tctl_q[1] <= '0;
            rld_q[0] <= '0;
            rld_q[1] <= '0;
            stagger_q <= 1'b0;
        end else begin
            if (wr_at(wr_q, wa_q, `CC_TCTL_A))
                tctl_q[0] <= hwdata[$bits(tmr_ctl_s)-1:0];
            if (wr_at(wr_q, wa_q, `CC_TCTL_B))
                tctl_q[1] <= hwdata[$bits(tmr_ctl_s)-1:0];
            if (wr_at(wr_q, wa_q, `CC_RLD_A))
                rld_q[0] <= hwdata[TW-1:0];
            if (wr_at(wr_q, wa_q, `CC_RLD_B))
                rld_q[1] <= hwdata[TW-1:0];
            if (wr_at(wr_q, wa_q, `CC_CFG))
                stagger_q <= hwdata[0];
        end
    end

    // A software load of the count beats a tick in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q[0] <= '0;
            cnt_q[1] <= '0;
            tick_q <= 2'h0;
            ovf_q <= 2'h0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                tick_q[t] <= tick[t];
                ovf_q[t] <= tick[t] && cnt_q[t] == TMAX;
                if (wr_at(wr_q, wa_q, t == 0 ? `CC_CNT_A : `CC_CNT_B))
                    cnt_q[t] <= hwdata[TW-1:0];
                else if (tick[t] && cnt_q[t] == TMAX)
                    cnt_q[t] <= rld_q[t];
                else if (tick[t])
                    cnt_q[t] <= cnt_q[t] + 1'b1;
            end
        end
    end

    // Channel array
    ch_ctl_s ctl_q [NCH];
    logic [TW-1:0] val_q [NCH];
    logic [NCH-1:0] done_q;
    logic [NCH-1:0] spent_q;
    logic [NCH-1:0] stat_q;
    logic [NCH-1:0] mask_q;
    logic [NCH-1:0] cap_in;
    logic [NCH-1:0] cap_prev_q;
    logic [NCH-1:0] cmp_ev;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] ev;
    logic [NCH-1:0] cmp_hi;
    logic [NPIN-1:0] pin_q;
    logic [NPIN-1:0] pin_d;
    logic [NPIN-1:0] oe_q;
    logic irq_q;

    assign cap_in = NCH'(cap_pin_in);
    assign ev = cmp_ev | cap_ev;
    assign cmp_hi = cmp_ev >> HALF;

    always_comb begin
        for (int k = 0; k < NCH; k++) begin
            logic hit;
            logic once;
            logic edge_seen;
            hit = tick_q[ctl_q[k].tsel]
                && cnt_q[ctl_q[k].tsel] == val_q[k];
            once = ctl_q[k].mode == CM_IRQ_ONCE
                || ctl_q[k].mode == CM_SET_CLEAR;
            cmp_ev[k] = ctl_q[k].func == FN_COMPARE && hit
                && !(once && done_q[k])
                && !(ctl_q[k].single && spent_q[k]);
            edge_seen = ctl_q[k].cap_fall ? cap_prev_q[k] && !cap_in[k]
                : !cap_prev_q[k] && cap_in[k];
            cap_ev[k] = (k < NPIN) && ctl_q[k].func == FN_CAPTURE
                && edge_seen;
        end
    end

    // Once-per-period lock: a match in the overflow cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= '0;
            spent_q <= '0;
            cap_prev_q <= '0;
        end else begin
            cap_prev_q <= cap_in;
            for (int k = 0; k < NCH; k++) begin
                if (cmp_ev[k])
                    done_q[k] <= 1'b1;
                else if (ovf_q[ctl_q[k].tsel])
                    done_q[k] <= 1'b0;
                if (ev[k] && ctl_q[k].single)
                    spent_q[k] <= 1'b1;
                else if (wr_q && wa_q[7:6] == `CC_CTL_REGION
                         && wa_q[5:2] == 4'(k))
                    spent_q[k] <= 1'b0;
            end
        end
    end

    // A capture beats a software write to the same register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < NCH; k++) begin
                ctl_q[k] <= '0;
                val_q[k] <= '0;
            end
        end else begin
            for (int k = 0; k < NCH; k++) begin
                if (wr_q && wa_q[7:6] == `CC_CTL_REGION
                    && wa_q[5:2] == 4'(k))
                    ctl_q[k] <= hwdata[$bits(ch_ctl_s)-1:0];
                if (cap_ev[k])
                    val_q[k] <= cnt_q[ctl_q[k].tsel];
                else if (wr_q && wa_q[7:6] == `CC_VAL_REGION
                         && wa_q[5:2] == 4'(k))
                    val_q[k] <= hwdata[TW-1:0];
            end
        end
    end

    // Sticky status: a new event wins over a write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wr_at(wr_q, wa_q, `CC_STAT))
                stat_q <= (stat_q & ~hwdata[NCH-1:0]) | ev;
            else
                stat_q <= stat_q | ev;
            if (wr_at(wr_q, wa_q, `CC_MASK))
                mask_q <= hwdata[NCH-1:0];
            irq_q <= |(stat_q & mask_q);
        end
    end

    // Pins: modes 0 and 2 never touch the pin level unless dbl is set
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            logic tog;
            tog = (ctl_q[p].mode == CM_TOGGLE || ctl_q[p].dbl)
                && cmp_ev[p];
            if (p < HALF && ctl_q[p].dbl && cmp_hi[p])
                tog = 1'b1;
            pin_d[p] = pin_q[p] ^ tog;
            if (ctl_q[p].func == FN_COMPARE && !ctl_q[p].dbl
                && ctl_q[p].mode == CM_SET_CLEAR) begin
                if (cmp_ev[p])
                    pin_d[p] = 1'b1;
                else if (ovf_q[ctl_q[p].tsel])
                    pin_d[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q <= '0;
            oe_q <= '0;
        end else begin
            pin_q <= pin_d;
            for (int p = 0; p < NPIN; p++)
                oe_q[p] <= ctl_q[p].func == FN_COMPARE;
        end
    end

    // Read mux, sampled in the address phase
    always_comb begin
        rd_d = `CC_WORD_RST;
        case (haddr[7:0])
            `CC_TCTL_A: rd_d = 32'(tctl_q[0]);
            `CC_TCTL_B: rd_d = 32'(tctl_q[1]);
            `CC_CNT_A: rd_d = 32'(cnt_q[0]);
            `CC_RLD_A: rd_d = 32'(rld_q[0]);
            `CC_CNT_B: rd_d = 32'(cnt_q[1]);
            `CC_RLD_B: rd_d = 32'(rld_q[1]);
            `CC_STAT: rd_d = 32'(stat_q);
            `CC_MASK: rd_d = 32'(mask_q);
            `CC_CFG: rd_d = 32'(stagger_q);
            default: begin
                if (haddr[7:6] == `CC_VAL_REGION)
                    rd_d = 32'(val_q[haddr[5:2]]);
                else if (haddr[7:6] == `CC_CTL_REGION)
                    rd_d = 32'(ctl_q[haddr[5:2]]);
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata_q <= `CC_WORD_RST;
        else if (bus_take && !hwrite)
            hrdata_q <= rd_d;
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cmp_pin_out = pin_q;
    assign cmp_pin_oe = oe_q;
    assign irq = irq_q;

    chk_timer_reload: assert property (
        tick[0] && cnt_q[0] == TMAX && !wr_q
        |=> cnt_q[0] == $past(rld_q[0]) && ovf_q[0])
        else $error("time base a did not reload on overflow");
    chk_timer_inc: assert property (
        tick[1] && cnt_q[1] != TMAX && !wr_q
        |=> cnt_q[1] == $past(cnt_q[1]) + 1'b1)
        else $error("time base b did not advance by one");
    chk_stagger_grid: assert property (
        stagger_q && tctl_q[0].src == SRC_PRESCALE && tick[0]
        |-> presc_q[2:0] == `CC_STAGGER_PHASE)
        else $error("staggered tick off the eight-cycle grid");
    chk_capture_latch: assert property (
        cap_ev[6] |=> val_q[6] == $past(cnt_q[ctl_q[6].tsel])
        && stat_q[6])
        else $error("capture did not latch timer value");
    chk_toggle_pin: assert property (
        cmp_ev[1] && ctl_q[1].mode == CM_TOGGLE && !ctl_q[1].dbl
        |=> pin_q[1] != $past(pin_q[1]))
        else $error("mode 1 match did not toggle pin");
    chk_irq_only: assert property (
        ctl_q[2].func == FN_COMPARE && !ctl_q[2].dbl
        && ctl_q[2].mode inside {CM_IRQ_MULTI, CM_IRQ_ONCE}
        |=> $stable(pin_q[2]))
        else $error("interrupt-only mode moved the pin");
    chk_once_period: assert property (
        cmp_ev[3] && ctl_q[3].mode inside {CM_IRQ_ONCE, CM_SET_CLEAR}
        ##1 !ovf_q[ctl_q[3].tsel] |-> !cmp_ev[3])
        else $error("second compare event in one period");
    chk_set_clear: assert property (
        ovf_q[ctl_q[3].tsel] && !cmp_ev[3] && !ctl_q[3].dbl
        && ctl_q[3].func == FN_COMPARE && ctl_q[3].mode == CM_SET_CLEAR
        |=> !pin_q[3])
        else $error("mode 3 pin not cleared on overflow");
    chk_single_event: assert property (
        ev[4] && ctl_q[4].single && !wr_q |=> !ev[4])
        else $error("single-event channel fired twice");
    chk_double_pin: assert property (
        cmp_ev[HALF + 5] && ctl_q[5].dbl && !cmp_ev[5]
        |=> pin_q[5] != $past(pin_q[5]))
        else $error("partner match did not toggle shared pin");
    chk_irq_level: assert property (
        ev[2] && mask_q[2] && !wr_q |-> ##2 irq)
        else $error("unmasked event did not raise interrupt");
endmodule : capture_compare_unit

// *** core/cc_map_map.svh ***
/*
 Register byte offsets and reset values of the capture/compare unit.
 Assumes decoding on haddr[7:0] of word-aligned AHB-Lite transfers.
*/
`ifndef CC_MAP_MAP_SVH
`define CC_MAP_MAP_SVH
`define CC_TCTL_A 8'h00
`define CC_TCTL_B 8'h04
`define CC_CNT_A 8'h08
`define CC_RLD_A 8'h0c
`define CC_CNT_B 8'h10
`define CC_RLD_B 8'h14
`define CC_STAT 8'h18
`define CC_MASK 8'h1c
`define CC_CFG 8'h20
`define CC_VAL_REGION 2'h1
`define CC_CTL_REGION 2'h2
`define CC_STAGGER_PHASE 3'h7
`define CC_WORD_RST 32'h0000_0000
`endif

// *** core/cc_pkg.sv ***
/*
 Types shared by the capture/compare unit: channel and timer controls.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cc_pkg;
    typedef enum logic [1:0] {
        FN_OFF = 2'h0, FN_CAPTURE = 2'h1, FN_COMPARE = 2'h2
    } func_e;
    typedef enum logic [1:0] {
        CM_IRQ_MULTI = 2'h0, CM_TOGGLE = 2'h1,
        CM_IRQ_ONCE = 2'h2, CM_SET_CLEAR = 2'h3
    } cmp_mode_e;
    typedef enum logic [1:0] {
        SRC_PRESCALE = 2'h0, SRC_NEIGHBOUR = 2'h1, SRC_EXTERNAL = 2'h2
    } src_e;
    // Channel control word, low byte of its register
    typedef struct packed {
        logic single;
        logic dbl;
        logic cap_fall;
        cmp_mode_e mode;
        func_e func;
        logic tsel;
    } ch_ctl_s;
    // Timer control word, low bits of its register
    typedef struct packed {
        logic run;
        src_e src;
        logic [2:0] div;
    } tmr_ctl_s;
endpackage : cc_pkg

// *** bench/cc_far_side.sv ***
/*
 Far-side model of the capture/compare unit: neighbour timer events,
 external count source and the capture trigger pins.
 Assumes the bench calls its tasks from one process, clocked by hclk.
*/
`timescale 1ns/1ps
module cc_far_side (
    // Clock
    input wire logic hclk,
    // Event sources
    output logic neighbour_evt,
    output logic ext_count_in,
    output logic [11:0] cap_pin_in
);
    // Pin 7 rests high so that a falling capture edge can be made later
    initial begin
        neighbour_evt = 1'b0;
        ext_count_in = 1'b0;
        cap_pin_in = 12'h080;
    end

    // The gap lets the neighbour timer be prompt or slow
    task automatic pulse(input int gap);
        repeat (gap) @(posedge hclk);
        neighbour_evt <= 1'b1;
        @(posedge hclk);
        neighbour_evt <= 1'b0;
    endtask : pulse

    task automatic ext(input int n);
        repeat (n) begin
            @(posedge hclk);
            ext_count_in <= 1'b1;
            repeat (2) @(posedge hclk);
            ext_count_in <= 1'b0;
            @(posedge hclk);
        end
        repeat (3) @(posedge hclk);
    endtask : ext

    task automatic cap_set(input logic [11:0] lvl);
        @(posedge hclk);
        cap_pin_in <= lvl;
    endtask : cap_set
endmodule : cc_far_side

// *** bench/tb_top.sv ***
/*
 Self-checking bench: AHB-Lite master, behavioural channel model, scenarios.
 Assumes the far-side model cc_far_side and the unit's register map header.
*/
`timescale 1ns/1ps
`include "cc_map_map.svh"
module tb_top
    import cc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, neighbour_evt, ext_count_in, irq;
    logic [11:0] cap_pin_in, cmp_pin_out, cmp_pin_oe;
    int errors = 0;
    int cmp_count = 0;
    int seed = 68;
    int cnt_a, rld_a;
    logic [15:0] m_stat = 16'h0;
    logic [15:0] m_mask = 16'h0;
    logic [11:0] m_pin = 12'h0;
    logic [15:0] val [16] = '{default: 16'h5};
    ch_ctl_s mc [16] = '{default: '0};
    bit lock [16];
    bit mute [16];
    logic [7:0] ra [10] = '{`CC_TCTL_A, `CC_TCTL_B, `CC_CNT_A, `CC_RLD_B,
        `CC_STAT, `CC_MASK, `CC_CFG, 8'h40, 8'h80, 8'h30};

    always #50 hclk = ~hclk;

    capture_compare_unit u_capture_compare_unit (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .neighbour_evt(neighbour_evt),
        .ext_count_in(ext_count_in), .cap_pin_in(cap_pin_in),
        .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .irq(irq)
    );

    cc_far_side u_cc_far_side (
        .hclk(hclk), .neighbour_evt(neighbour_evt),
        .ext_count_in(ext_count_in), .cap_pin_in(cap_pin_in)
    );

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            conclude();
        end
    endtask : wait_rdy

    // Each call starts one edge later, so an idle cycle separates any two transfers
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        bus(1'b0, a, 32'h0);
        chk(what, e, rd);
    endtask : rc

    // One neighbour event on time base a, then model and design compared
    task automatic step();
        bit ovf;
        u_cc_far_side.pulse(1 + {$random(seed)} % 4);
        ovf = (cnt_a == 'hffff);
        cnt_a = ovf ? rld_a : cnt_a + 1;
        for (int c = 0; c < 16; c++) begin
            if (ovf) begin
                lock[c] = 0;
                if (c < 12 && mc[c].mode == CM_SET_CLEAR) m_pin[c] = 1'b0;
            end
            if (mc[c].func == FN_COMPARE && !mc[c].tsel && val[c] == cnt_a
                && !lock[c] && !mute[c]) begin
                m_stat[c] = 1'b1;
                mute[c] = mc[c].single;
                lock[c] = mc[c].mode inside {CM_IRQ_ONCE, CM_SET_CLEAR};
                if (c < 12 && mc[c].mode == CM_TOGGLE) m_pin[c] = ~m_pin[c];
                if (c < 12 && mc[c].mode == CM_SET_CLEAR) m_pin[c] = 1'b1;
                if (c >= 8 && mc[c - 8].dbl) m_pin[c - 8] = ~m_pin[c - 8];
            end
        end
        repeat (5) @(posedge hclk);
        chk("pins", {20'h0, m_pin}, {20'h0, cmp_pin_out});
        chk("irq", {31'h0, |(m_stat & m_mask)}, {31'h0, irq});
        rc(`CC_STAT, {16'h0, m_stat}, "stat");
        rc(`CC_CNT_A, cnt_a, "cnt_a");
    endtask : step

    // Runs time base b for about 403 cycles, expects one tick per period
    task automatic rate(input logic [31:0] ctl, input int per);
        wr(`CC_CNT_B, 32'h0);
        wr(`CC_TCTL_B, ctl);
        repeat (400) @(posedge hclk);
        wr(`CC_TCTL_B, 32'h0);
        bus(1'b0, `CC_CNT_B, 32'h0);
        chk("rate", 32'h1, {31'h0, rd + 2 >= 400 / per
            && rd <= 400 / per + 4});
    endtask : rate

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk("idle", 32'h0, {7'h0, irq, cmp_pin_oe, cmp_pin_out});
        foreach (ra[i]) rc(ra[i], 32'h0, "reset value");
        wr(8'h30, 32'hffff_ffff);
        rc(8'h30, 32'h0, "unmapped");
        rld_a = $random(seed);
        wr(`CC_RLD_B, rld_a);
        rc(`CC_RLD_B, {16'h0, rld_a[15:0]}, "rld_b");
        for (int c = 0; c < 6; c++) begin
            mc[c] = '{c == 4, c == 5, 1'b0,
                c < 4 ? cmp_mode_e'(c) : CM_TOGGLE, FN_COMPARE, 1'b0};
        end
        mc[13] = '{1'b0, 1'b0, 1'b0, CM_IRQ_MULTI, FN_COMPARE, 1'b0};
        val[13] = 16'h4;
        mc[8] = '{1'b0, 1'b0, 1'b0, CM_IRQ_MULTI, FN_COMPARE, 1'b1};
        mc[6] = '{1'b0, 1'b0, 1'b0, CM_IRQ_MULTI, FN_CAPTURE, 1'b0};
        mc[7] = '{1'b0, 1'b0, 1'b1, CM_IRQ_MULTI, FN_CAPTURE, 1'b0};
        for (int c = 0; c < 16; c++) begin
            wr(8'h40 + 8'(4 * c), {16'h0, val[c]});
            wr(8'h80 + 8'(4 * c), {24'h0, mc[c]});
            rc(8'h80 + 8'(4 * c), {24'h0, mc[c]}, "ctl");
        end
        wr(`CC_MASK, 32'h4);
        m_mask = 16'h4;
        rld_a = 3;
        cnt_a = 3;
        wr(`CC_RLD_A, 32'h3);
        wr(`CC_CNT_A, 32'h3);
        wr(`CC_TCTL_A, 32'h28);
        chk("oe", 32'h13f, {20'h0, cmp_pin_oe});
        repeat (2) step();
        wr(`CC_STAT, 32'hffff);
        m_stat = 16'h0;
        repeat (2) @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`CC_CNT_A, 32'h4);
        cnt_a = 4;
        step();
        wr(`CC_CNT_A, 32'hfffe);
        cnt_a = 'hfffe;
        repeat (4) step();
        u_cc_far_side.cap_set(12'h040);
        m_stat[7:6] = 2'h3;
        repeat (4) @(posedge hclk);
        rc(8'h58, cnt_a, "capture rise");
        rc(8'h5c, cnt_a, "capture fall");
        rc(`CC_STAT, {16'h0, m_stat}, "capture stat");
        wr(`CC_CNT_A, 32'h0);
        wr(`CC_TCTL_A, 32'h30);
        u_cc_far_side.ext(5);
        rc(`CC_CNT_A, 32'h5, "ext count");
        rate(32'h20, 1);
        rate(32'h22, 4);
        wr(`CC_CFG, 32'h1);
        rate(32'h20, 8);
        conclude();
    end
endmodule : tb_top
